/* File: logic/aoc_params.svh */
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH
// register indices on the plain register port
`define AOC_ADDR_CFG 4'h0
`define AOC_ADDR_STAT 4'h1
// configuration register bit positions
`define AOC_CFG_DDR 0
`define AOC_CFG_EDGE 1
`define AOC_CFG_SWING 2
`define AOC_CFG_DES 3
`define AOC_CFG_QSEL 4
`define AOC_CFG_BGCAL 5
`define AOC_CFG_DCC 6
// reset: ddr, background phase cal and duty-cycle correction on
`define AOC_CFG_RST 16'h0061
// three-level launch-edge pin codes; anything else is floating
`define AOC_LVL_LOW 2'h0
`define AOC_LVL_HIGH 2'h3
// calibration request qualifier, sampling-clock cycles per phase
`define AOC_CAL_REQ 10'h280
// pipeline: taps give 13 and 14 cycles with the output register
`define AOC_PIPE_LEN 13
`define AOC_TAP_PRI 11
`define AOC_TAP_DEL 12
// cycles of invalid words after leaving power down
`define AOC_REFILL 5'h10
`endif

/* File: logic/aoc_pkg.sv */
package aoc_pkg;
  // calibration sequencer states
  typedef enum logic [1:0] {
    CAL_WAIT,
    CAL_RUN,
    CAL_IDLE
  } aoc_cal_e;

  // whole state of the core in one record
  typedef struct packed {
    logic pd_s1;
    logic pd_s2;
    logic pdq_s1;
    logic pdq_s2;
    logic calr_s1;
    logic calr_s2;
    logic [1:0] es_s1;
    logic [1:0] es_s2;
    logic des_s1;
    logic des_s2;
    logic ece_s1;
    logic ece_s2;
    logic sw_s1;
    logic sw_s2;
    logic dly_s1;
    logic dly_s2;
    logic [15:0] cfg;
    logic [15:0] rdata;
    aoc_cal_e cst;
    logic [31:0] cnt;
    logic [9:0] req_lo;
    logic [9:0] req_hi;
    logic pd;
    logic [4:0] refill;
    logic valid;
    logic qcal_ok;
    logic [12:0][7:0] pipe_i;
    logic [12:0][7:0] pipe_q;
    logic ddr;
    logic edge_rise;
    logic des;
    logic qsel;
    logic ph;
    logic output_data_clock;
    logic [7:0] ip;
    logic [7:0] id;
    logic [7:0] qp;
    logic [7:0] qd;
    logic oe;
    logic oor;
    logic swing;
    logic dcc;
    logic [7:0] phase_trim;
    logic cal_act;
  } aoc_state_s;
endpackage : aoc_pkg

/* File: logic/aoc_core.sv */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "aoc_params.svh"

// How it works
// - dual-edge: converters sample on opposite clock edges
// - dual-edge words ordered qd, id, qp, ip
// - normal: primary 13 cycles, delayed 14 cycles
// - dual-edge q buses carry rise samples
// - dual-edge pin mode samples I only; registers choose
// - background phase tracking in dual-edge mode
// - duty-cycle correction enabled by default
// - sdr data changes on chosen clock edge
// - sdr clock at word rate, ddr half
// - floating launch pin selects ddr clocking
// - power down: data off, clock and flag low
// - q power down silences only q
// - words invalid until pipeline refills
// - power down waits for running calibration
// - power-up delay frozen while powered down
// - calibration request ignored while powered down
// - calibration skips q while q is off
// - calibration flag high throughout calibration
// - extended control overrides the mode pins
module aoc_core #(
  parameter int unsigned DLY_SHORT = 32'h0200_0000, // short power-up delay
  parameter int unsigned DLY_LONG = 32'h8000_0000, // long power-up delay
  parameter int unsigned CAL_LEN = 32'h0000_8000 // calibration length
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] i_fall_sample_i,
  input wire logic [7:0] q_fall_sample_i,
  input wire logic [7:0] i_rise_sample_i,
  input wire logic [7:0] q_rise_sample_i,
  input wire logic full_power_down_i,
  input wire logic q_channel_power_down_i,
  input wire logic calibration_request_i,
  input wire logic [1:0] launch_edge_level_i,
  input wire logic dual_edge_enable_i,
  input wire logic ext_control_enable_i,
  input wire logic output_swing_select_i,
  input wire logic cal_delay_select_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [7:0] i_bus_primary_o,
  output logic [7:0] i_bus_delayed_o,
  output logic [7:0] q_bus_primary_o,
  output logic [7:0] q_bus_delayed_o,
  output logic data_oe_o,
  output logic output_data_clock_o,
  output logic out_of_range_flag_o,
  output logic calibration_active_o,
  output logic output_swing_o,
  output logic dcc_enable_o,
  output logic word_valid_o
);

  aoc_pkg::aoc_state_s st; // registered state
  aoc_pkg::aoc_state_s d; // next state

  // a byte at either rail means the input left the range
  function automatic logic aoc_rail(input logic [7:0] b);
    aoc_rail = (b == 8'h00) || (b == 8'hff);
  endfunction

  // all next-state logic
  always_comb begin
    logic cal_go;
    logic [31:0] dly_lim;
    logic [7:0] i_in;
    logic [7:0] q_in;
    cal_go = 1'b0;
    dly_lim = DLY_SHORT;
    i_in = i_fall_sample_i;
    q_in = q_fall_sample_i;
    d = st;
    // two-flop synchronisers on every pin input
    d.pd_s1 = full_power_down_i;
    d.pd_s2 = st.pd_s1;
    d.pdq_s1 = q_channel_power_down_i;
    d.pdq_s2 = st.pdq_s1;
    d.calr_s1 = calibration_request_i;
    d.calr_s2 = st.calr_s1;
    d.es_s1 = launch_edge_level_i;
    d.es_s2 = st.es_s1;
    d.des_s1 = dual_edge_enable_i;
    d.des_s2 = st.des_s1;
    d.ece_s1 = ext_control_enable_i;
    d.ece_s2 = st.ece_s1;
    d.sw_s1 = output_swing_select_i;
    d.sw_s2 = st.sw_s1;
    d.dly_s1 = cal_delay_select_i;
    d.dly_s2 = st.dly_s1;

    // software writes the configuration word
    if (reg_wr_i && reg_addr_i == `AOC_ADDR_CFG) begin
      d.cfg = reg_wdata_i;
    end
    // read data stands for one cycle only; unmapped reads zero
    d.rdata = 16'h0000;
    if (reg_rd_i) begin
      if (reg_addr_i == `AOC_ADDR_CFG) begin
        d.rdata = st.cfg;
      end else if (reg_addr_i == `AOC_ADDR_STAT) begin
        d.rdata = {st.phase_trim, 2'b00, st.ddr, st.des,
                   st.qcal_ok, st.valid, st.pd, st.cal_act};
      end
    end

    // effective modes: registers in extended control, else pins
    if (st.ece_s2) begin
      d.ddr = d.cfg[`AOC_CFG_DDR];
      d.edge_rise = d.cfg[`AOC_CFG_EDGE];
      d.des = d.cfg[`AOC_CFG_DES];
      d.qsel = d.cfg[`AOC_CFG_QSEL];
      d.swing = d.cfg[`AOC_CFG_SWING];
      d.dcc = d.cfg[`AOC_CFG_DCC];
    end else begin
      // mid-level pin means ddr; high or low pick the sdr edge
      d.ddr = (st.es_s2 != `AOC_LVL_LOW) && (st.es_s2 != `AOC_LVL_HIGH);
      d.edge_rise = (st.es_s2 == `AOC_LVL_HIGH);
      d.des = st.des_s2;
      d.qsel = 1'b0;
      d.swing = st.sw_s2;
      d.dcc = 1'b1;
    end

    // power-up delay length; extended control has the short one only
    if (!st.ece_s2 && st.dly_s2) begin
      dly_lim = DLY_LONG;
    end

    // request qualifier: long low then long high; dropped in power down
    if (st.pd) begin
      d.req_lo = 10'h000;
      d.req_hi = 10'h000;
    end else if (!st.calr_s2) begin
      d.req_hi = 10'h000;
      if (st.req_lo != `AOC_CAL_REQ) begin
        d.req_lo = st.req_lo + 10'h001;
      end
    end else if (st.req_lo == `AOC_CAL_REQ) begin
      if (st.req_hi == `AOC_CAL_REQ - 10'h001) begin
        cal_go = 1'b1;
        d.req_lo = 10'h000;
        d.req_hi = 10'h000;
      end else begin
        d.req_hi = st.req_hi + 10'h001;
      end
    end

    // q calibration goes stale whenever q is switched off
    if (st.pdq_s2) begin
      d.qcal_ok = 1'b0;
    end

    // calibration sequencer
    unique case (st.cst)
      aoc_pkg::CAL_WAIT: begin
        // delay counter frozen while the power-down pin is high
        // also wait for the lagging power-down state so a run never starts powered down
        if (!st.pd_s2 && !st.pd) begin
          if (st.cnt == dly_lim - 32'h0000_0001) begin
            d.cst = aoc_pkg::CAL_RUN;
            d.cnt = 32'h0000_0000;
          end else begin
            d.cnt = st.cnt + 32'h0000_0001;
          end
        end
      end
      aoc_pkg::CAL_RUN: begin
        if (st.cnt == 32'(CAL_LEN - 1)) begin
          d.cst = aoc_pkg::CAL_IDLE;
          d.cnt = 32'h0000_0000;
          d.qcal_ok = !st.pdq_s2;
        end else begin
          d.cnt = st.cnt + 32'h0000_0001;
        end
      end
      aoc_pkg::CAL_IDLE: begin
        // a request seen in power down never starts later
        if (cal_go && !st.pd) begin
          d.cst = aoc_pkg::CAL_RUN;
        end
      end
      default: begin
        // unused code: park the sequencer idle
        d.cst = aoc_pkg::CAL_IDLE;
      end
    endcase
    d.cal_act = (d.cst == aoc_pkg::CAL_RUN);

    // power down follows the pin except while calibrating
    if (d.cst != aoc_pkg::CAL_RUN) begin
      d.pd = st.pd_s2;
    end

    // refill timer: the pipeline holds stale words after waking
    if (d.pd) begin
      d.refill = `AOC_REFILL;
    end else if (st.refill != 5'h00) begin
      d.refill = st.refill - 5'h01;
    end
    d.valid = !d.pd && (d.refill == 5'h00);

    // converter inputs: dual-edge feeds both from one input
    if (d.des) begin
      i_in = d.qsel ? q_fall_sample_i : i_fall_sample_i;
      q_in = d.qsel ? q_rise_sample_i : i_rise_sample_i;
    end
    if (st.pdq_s2) begin
      q_in = 8'h00;
    end
    d.pipe_i = {st.pipe_i[`AOC_PIPE_LEN-2:0], i_in};
    d.pipe_q = {st.pipe_q[`AOC_PIPE_LEN-2:0], q_in};

    // background phase tracking nudges a trim toward equal levels
    if (d.des && !d.pd && (!st.ece_s2 || d.cfg[`AOC_CFG_BGCAL])) begin
      if (q_in > i_in && st.phase_trim != 8'hff) begin
        d.phase_trim = st.phase_trim + 8'h01;
      end else if (q_in < i_in && st.phase_trim != 8'h00) begin
        d.phase_trim = st.phase_trim - 8'h01;
      end
    end

    // output word every second cycle; 1:2 demux per converter
    d.ph = !st.ph;
    if (d.pd) begin
      // buses released; clock and range flag held low
      d.ip = 8'h00;
      d.id = 8'h00;
      d.qp = 8'h00;
      d.qd = 8'h00;
      d.output_data_clock = 1'b0;
      d.oor = 1'b0;
    end else if (st.ph) begin
      // all four bytes load together; rise samples lead by half a cycle,
      // so oldest to newest reads qd, id, qp, ip in dual-edge mode
      d.ip = st.pipe_i[`AOC_TAP_PRI];
      d.id = st.pipe_i[`AOC_TAP_DEL];
      d.qp = st.pipe_q[`AOC_TAP_PRI];
      d.qd = st.pipe_q[`AOC_TAP_DEL];
      d.oor = aoc_rail(st.pipe_i[`AOC_TAP_PRI]) || aoc_rail(st.pipe_i[`AOC_TAP_DEL])
              || aoc_rail(st.pipe_q[`AOC_TAP_PRI]) || aoc_rail(st.pipe_q[`AOC_TAP_DEL]);
      // ddr toggles per word; sdr puts the chosen edge on the word
      d.output_data_clock = d.ddr ? !st.output_data_clock : d.edge_rise;
    end else if (!d.ddr) begin
      d.output_data_clock = !d.edge_rise;
    end
    d.oe = !d.pd;
  end

  // one register for the whole state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.cfg <= `AOC_CFG_RST;
    end else begin
      st <= d;
    end
  end

  // outputs come straight from the state flops
  assign reg_rdata_o = st.rdata;
  assign i_bus_primary_o = st.ip;
  assign i_bus_delayed_o = st.id;
  assign q_bus_primary_o = st.qp;
  assign q_bus_delayed_o = st.qd;
  assign data_oe_o = st.oe;
  assign output_data_clock_o = st.output_data_clock;
  assign out_of_range_flag_o = st.oor;
  assign calibration_active_o = st.cal_act;
  assign output_swing_o = st.swing;
  assign dcc_enable_o = st.dcc;
  assign word_valid_o = st.valid;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // power down releases the buses and holds clock and flag low
  a_pd_outputs_off: assert property (st.pd |-> !data_oe_o && !output_data_clock_o && !out_of_range_flag_o)
    else $error("outputs active in power down");
  // never powered down during a calibration
  a_pd_defers_cal: assert property (st.cst == aoc_pkg::CAL_RUN |-> !st.pd)
    else $error("power down entered during calibration");
  // idle sequencer stays idle while powered down
  a_cal_ignored_pd: assert property (st.pd && st.cst == aoc_pkg::CAL_IDLE |=> st.cst == aoc_pkg::CAL_IDLE)
    else $error("calibration started in power down");
  // power-up delay counter holds while the pin is high
  a_delay_frozen: assert property (st.cst == aoc_pkg::CAL_WAIT && st.pd_s2 |=> $stable(st.cnt))
    else $error("power-up delay advanced in power down");
  // words stay invalid for a while after waking
  a_refill_invalid: assert property ($fell(st.pd) |-> !word_valid_o [*8])
    else $error("word valid too soon after power down");
  // q primary bus silent once q has been off long enough to flush the 13-deep pipe
  a_q_silent: assert property (st.pdq_s2 [*8] ##1 st.pdq_s2 [*8] |-> q_bus_primary_o == 8'h00)
    else $error("q bus active while q powered down");
  // sdr words change with the chosen clock level
  a_sdr_edge: assert property (!st.ddr && !st.pd && !$past(st.pd) && $changed(i_bus_primary_o)
                               |-> output_data_clock_o == st.edge_rise)
    else $error("sdr data launched on wrong edge");
  // calibration flag tracks the running state
  a_cal_flag: assert property ($rose(st.cst == aoc_pkg::CAL_RUN) |-> calibration_active_o ##1 calibration_active_o)
    else $error("calibration flag missing");
  // ddr clock toggles once per word
  a_ddr_toggle: assert property (st.ddr && $past(st.ddr) && !st.pd && !$past(st.pd) && $past(st.ph)
                                 |-> output_data_clock_o != $past(output_data_clock_o))
    else $error("ddr clock did not toggle");

endmodule // aoc_core
`default_nettype wire

/* File: verification/aoc_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
// receiving logic device: counts words taken on the forwarded clock
module aoc_rx_model (
  input wire logic ref_clk_i,
  input wire logic output_data_clock_i,
  input wire logic ddr_i,
  input wire logic rise_i,
  output var int words_o
);
  logic prev_q = 1'b0; // last clock level seen
  initial words_o = 0;
  // ddr takes on both edges; sdr takes on the edge away from the launch edge
  always @(posedge ref_clk_i) begin
    if (output_data_clock_i !== prev_q && (ddr_i || output_data_clock_i !== rise_i)) begin
      words_o <= words_o + 1;
    end
    prev_q <= output_data_clock_i;
  end
endmodule // aoc_rx_model
`default_nettype wire

/* File: verification/aoc_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module aoc_core_tb;
  localparam int CL = 20; // shortened calibration length
  logic ref_clk_i = 0, rst_i = 1;
  logic [7:0] i_fall_sample_i = 0, q_fall_sample_i = 0, i_rise_sample_i = 0, q_rise_sample_i = 0;
  logic full_power_down_i = 1, q_channel_power_down_i = 0, calibration_request_i = 0;
  logic dual_edge_enable_i = 0, ext_control_enable_i = 0, output_swing_select_i = 0, cal_delay_select_i = 0;
  logic [1:0] launch_edge_level_i = 2'h3;
  logic [3:0] reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o;
  logic reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] i_bus_primary_o, i_bus_delayed_o, q_bus_primary_o, q_bus_delayed_o;
  logic data_oe_o, output_data_clock_o, out_of_range_flag_o, calibration_active_o;
  logic output_swing_o, dcc_enable_o, word_valid_o;
  int failures = 0, compares = 0, cyc = 0, rises = 0, words, rx_words;
  logic [31:0] hist [32]; // inputs per cycle: i fall, q fall, i rise, q rise
  logic [31:0] prev_w; // word seen last cycle
  logic prev_c; // forwarded clock last cycle
  logic [2:0] swh = 3'h0; // swing pin seen on the last three falling edges
  bit chk = 0, m_des = 0, m_qsel = 0, m_ddr = 1, m_rise = 0, m_pdq = 0; // model mode
  aoc_core #(.DLY_SHORT(16), .DLY_LONG(32), .CAL_LEN(CL)) DUT (
    .ref_clk_i, .rst_i, .i_fall_sample_i, .q_fall_sample_i, .i_rise_sample_i, .q_rise_sample_i,
    .full_power_down_i, .q_channel_power_down_i, .calibration_request_i, .launch_edge_level_i,
    .dual_edge_enable_i, .ext_control_enable_i, .output_swing_select_i, .cal_delay_select_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .i_bus_primary_o,
    .i_bus_delayed_o, .q_bus_primary_o, .q_bus_delayed_o, .data_oe_o, .output_data_clock_o,
    .out_of_range_flag_o, .calibration_active_o, .output_swing_o, .dcc_enable_o, .word_valid_o);
  aoc_rx_model RX (.ref_clk_i, .output_data_clock_i(output_data_clock_o), .ddr_i(m_ddr), .rise_i(m_rise),
    .words_o(rx_words));
  always #2 ref_clk_i = ~ref_clk_i;
  // fresh converter results and swing pin every cycle
  always @(posedge ref_clk_i) begin
    i_fall_sample_i <= 8'($urandom);
    q_fall_sample_i <= 8'($urandom);
    i_rise_sample_i <= 8'($urandom);
    q_rise_sample_i <= 8'($urandom);
    output_swing_select_i <= 1'($urandom);
  end
  task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // model: i and q byte of the sample taken a cycles ago
  function automatic logic [15:0] src(int a);
    logic [31:0] h;
    h = hist[(cyc - a) & 31];
    return {(m_des && m_qsel) ? h[23:16] : h[31:24],
      m_pdq ? 8'h00 : m_des ? (m_qsel ? h[7:0] : h[15:8]) : h[23:16]};
  endfunction
  // a byte at either rail flags out of range
  function automatic bit rl(input logic [7:0] b);
    return b == 8'h00 || b == 8'hff;
  endfunction
  // a fresh word is 13/14 cycles old, a held one 14/15
  always @(negedge ref_clk_i) begin
    logic [31:0] w;
    logic [31:0] e;
    w = {i_bus_primary_o, q_bus_primary_o, i_bus_delayed_o, q_bus_delayed_o};
    cyc++;
    hist[cyc & 31] = {i_fall_sample_i, q_fall_sample_i, i_rise_sample_i, q_rise_sample_i};
    e = (w !== prev_w) ? {src(13), src(14)} : {src(14), src(15)};
    if (chk) begin
      chk_bits(w, e);
      if (w !== prev_w) chk_bits(output_data_clock_o, m_ddr ? !prev_c : m_rise);
      chk_bits(out_of_range_flag_o, rl(e[31:24]) || rl(e[23:16]) || rl(e[15:8]) || rl(e[7:0]));
      chk_bits(output_swing_o, ext_control_enable_i ? 1'b0 : swh[2]);
      chk_bits(data_oe_o, 1'b1);
      rises += 32'(output_data_clock_o && !prev_c);
    end
    prev_w = w;
    prev_c = output_data_clock_o;
    swh = {swh[1:0], output_swing_select_i};
  end
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_o;
  endtask
  // request pin low a little over the qualifying time, then left high
  task automatic cal_req();
    calibration_request_i <= 1'b0;
    repeat (660) @(posedge ref_clk_i);
    calibration_request_i <= 1'b1;
  endtask
  // wait bounded for a calibration, optionally ask for power down in it, time it
  task automatic cal_time(input int bound, input bit pd_mid, output int n);
    n = 0;
    for (int k = 0; k < bound && calibration_active_o !== 1'b1; k++) @(negedge ref_clk_i);
    if (pd_mid && calibration_active_o === 1'b1) full_power_down_i <= 1'b1;
    while (calibration_active_o === 1'b1 && n < 1000) begin
      n++;
      @(negedge ref_clk_i);
    end
  endtask
  // set pins and model, let the pipe settle, then watch 40 cycles
  task automatic run_mode(input logic [1:0] l, input bit dp, d, q, dd, r);
    @(posedge ref_clk_i);
    launch_edge_level_i <= l;
    dual_edge_enable_i <= dp;
    {m_des, m_qsel, m_ddr, m_rise} = {d, q, dd, r};
    repeat (40) @(negedge ref_clk_i);
    words = rx_words;
    rises = 0;
    chk = 1;
    repeat (40) @(negedge ref_clk_i);
    chk = 0;
    chk_bits(rises, dd ? 10 : 20);
    chk_bits(rx_words - words, 20);
    $display("window level %b dual %b done", l, d);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] r;
    int n;
    void'($urandom(82588));
    repeat (2) @(posedge ref_clk_i);
    chk_bits({data_oe_o, output_data_clock_o, calibration_active_o, word_valid_o, reg_rdata_o}, 0);
    rst_i <= 1'b0;
    rd_reg(4'h0, r);
    chk_bits(r, 16'h0061);
    chk_bits(dcc_enable_o, 1'b1);
    repeat (60) @(negedge ref_clk_i);
    chk_bits({calibration_active_o, data_oe_o, output_data_clock_o, out_of_range_flag_o}, 0);
    rd_reg(4'h1, r);
    chk_bits(r[1], 1'b1);
    full_power_down_i <= 1'b0;
    cal_time(80, 1, n);
    chk_bits(n, CL);
    repeat (10) @(negedge ref_clk_i);
    chk_bits({data_oe_o, output_data_clock_o, out_of_range_flag_o, prev_w}, 0);
    cal_req();
    cal_time(700, 0, n);
    chk_bits(n, 0);
    full_power_down_i <= 1'b0;
    for (n = 0; n < 10 && data_oe_o !== 1'b1; n++) @(negedge ref_clk_i);
    for (n = 0; n < 40 && word_valid_o !== 1'b1; n++) @(negedge ref_clk_i);
    chk_bits(n >= 13 && n <= 17, 1'b1);
    cal_time(1000, 0, n);
    chk_bits(n, 0);
    $display("power down and power-up calibration done");
    q_channel_power_down_i <= 1'b1;
    cal_req();
    cal_time(700, 0, n);
    chk_bits(n, CL);
    m_pdq = 1;
    run_mode(2'h3, 0, 0, 0, 0, 1);
    q_channel_power_down_i <= 1'b0;
    m_pdq = 0;
    rd_reg(4'h1, r);
    chk_bits(r[3], 1'b0);
    cal_req();
    cal_time(700, 0, n);
    rd_reg(4'h1, r);
    chk_bits(r[3], 1'b1);
    for (int k = 0; k < 8; k++) begin
      run_mode(2'(k >> 1), k[0], k[0], 0, k[2] ^ k[1], k[2:1] == 2'h3);
    end
    calibration_request_i <= 1'b0;
    ext_control_enable_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cal_time(80, 0, n);
    chk_bits(n, CL);
    run_mode(2'h0, 1, 0, 0, 1, 0);
    wr_reg(4'h0, 16'h0079);
    wr_reg(4'h7, 16'hffff);
    rd_reg(4'h0, r);
    chk_bits(r, 16'h0079);
    rd_reg(4'h7, r);
    chk_bits(r, 16'h0000);
    run_mode(2'h0, 0, 1, 1, 1, 0);
    tally_and_finish();
  end
endmodule // aoc_core_tb
`default_nettype wire
